// File: verilog/smb_master_port.v
/*
 * Single master two-wire bus unit: pin configuration, SCL generation with
 * clock synchronisation, start generation and bus state flags.
 * Assumes the pins are external and asynchronous to sys_clk; the control
 * inputs come from logic on sys_clk.
 */
`include "smb_regs.vh"

// What this block does
// - Slow-output select forces slow-fall drive on clock and SDA pins; SDO slow drive follows its own bits only.
// - Clock pin mode follows its four port-control bits.
// - Data pin receive stays enabled; output mode follows its own four bits.
// - Three-wire mode drives a separate data output pin by its bits.
// - Generated SCL counts equal high and low halves; the high half also waits for the observed rise.
// - SCL high width is timed from the observed rising edge.
// - Slow SCL rise delays the high phase, lowering the rate.
// - Start and stop are SDA edges while SCL is high.
// - SDA changes only while SCL is low, except start and stop.
// - Writing EDh or ECh with run set begins a start condition.
// - Control bit zero is the interrupt request enable.
// - Filter period is one to four clocks; SCL period scales by n+1.
// - Overrun sets on SCL fall while not busy outside three-wire mode, held until cleared.
module smb_master_port (
   input wire sys_clk,
   input wire rst,
   input wire ctrl_wr,
   input wire [7:0] ctrl_wdata,
   output reg [7:0] ctrl_rdata,
   output reg interrupt_request_enable,
   output reg bus_busy_flag,
   output reg overrun_flag,
   input wire overrun_clear,
   input wire [1:0] filter_divider_field,
   input wire speed_mode_select,
   input wire [4:0] scl_divider_field,
   input wire serial_sync_mode,
   input wire slow_output_select,
   input wire input_threshold_select,
   output reg cmos_threshold,
   input wire [6:4] port_function_select_a,
   input wire [6:4] port_function_select_b,
   input wire [6:4] port_output_latch,
   input wire [6:4] port_direction_bits,
   input wire scl_pin_in,
   output reg scl_pin_out,
   output reg scl_pin_oe,
   output reg scl_pin_slow,
   input wire sda_pin_in,
   output reg sda_pin_out,
   output reg sda_pin_oe,
   output reg sda_pin_slow,
   output reg sda_rx_enable,
   output reg sdo_pin_out,
   output reg sdo_pin_oe,
   output reg sdo_pin_slow
);
   localparam ST_IDLE = 6'b000001;
   localparam ST_SETUP = 6'b000010;
   localparam ST_HOLD = 6'b000100;
   localparam ST_LOW = 6'b001000;
   localparam ST_WAIT = 6'b010000;
   localparam ST_HIGH = 6'b100000;

   reg [7:0] ctrl_reg;
   reg [5:0] state_reg;
   reg [5:0] state_next;
   reg [1:0] tick_cnt_reg;
   reg [7:0] ph_cnt_reg;
   reg [7:0] ph_cnt_next;
   reg scl_gen_reg;
   reg scl_gen_next;
   reg sda_gen_reg;
   reg sda_gen_next;
   reg busy_next;
   reg ovr_next;
   reg scl_out_next;
   reg scl_oe_next;
   reg sda_out_next;
   reg sda_oe_next;
   reg sdo_out_next;
   reg sdo_oe_next;

   wire scl_lvl;
   wire scl_rose;
   wire scl_fell;
   wire sda_lvl;
   wire sda_rose;
   wire sda_fell;
   wire tick;
   wire [7:0] half_ticks;
   wire half_done;
   wire start_cmd;
   wire [3:0] scl_sel;
   wire [3:0] sda_sel;
   wire [3:0] sdo_sel;

   // Maps the four port-control bits of one pin to its output mode.
   function [1:0] pin_mode;
      input [3:0] sel;
      begin
         case (sel)
            `SMB_SEL_OPEN: pin_mode = `SMB_MODE_OPEN;
            `SMB_SEL_CMOS: pin_mode = `SMB_MODE_CMOS;
            `SMB_SEL_SLOW: pin_mode = `SMB_MODE_CMOS;
            `SMB_SEL_OD: pin_mode = `SMB_MODE_OD;
            default: pin_mode = `SMB_MODE_GPIO;
         endcase
      end
   endfunction

   // Output enable for a pin that carries level val in the given mode.
   // Outside the serial modes, direction 0 drives the latch and 1 releases.
   function pin_oe;
      input [3:0] sel;
      input val;
      begin
         case (pin_mode(sel))
            `SMB_MODE_OPEN: pin_oe = 1'b0;
            `SMB_MODE_CMOS: pin_oe = 1'b1;
            `SMB_MODE_OD: pin_oe = ~val;
            default: pin_oe = ~sel[0];
         endcase
      end
   endfunction

   function pin_out;
      input [3:0] sel;
      input val;
      begin
         case (pin_mode(sel))
            `SMB_MODE_CMOS: pin_out = val;
            `SMB_MODE_GPIO: pin_out = sel[1];
            default: pin_out = 1'b0;
         endcase
      end
   endfunction

   smb_line_sync u_scl_sync (
      .clk(sys_clk),
      .rst(rst),
      .line_in(scl_pin_in),
      .level(scl_lvl),
      .rose(scl_rose),
      .fell(scl_fell)
   );

   smb_line_sync u_sda_sync (
      .clk(sys_clk),
      .rst(rst),
      .line_in(sda_pin_in),
      .level(sda_lvl),
      .rose(sda_rose),
      .fell(sda_fell)
   );

   assign scl_sel = {port_function_select_a[4], port_function_select_b[4],
      port_output_latch[4], port_direction_bits[4]};
   assign sda_sel = {port_function_select_a[5], port_function_select_b[5],
      port_output_latch[5], port_direction_bits[5]};
   assign sdo_sel = {port_function_select_a[6], port_function_select_b[6],
      port_output_latch[6], port_direction_bits[6]};

   // Filter tick every filter_divider_field+1 clocks; half SCL period is
   // (n+1) ticks in fast mode and (n+1)*4 in standard mode.
   assign tick = (tick_cnt_reg == filter_divider_field);
   assign half_ticks = ({3'h0, scl_divider_field} + 8'h01) *
      (speed_mode_select ? `SMB_HALF_STD : `SMB_HALF_FAST);
   assign half_done = tick && (ph_cnt_reg + 8'h01 == half_ticks);
   assign start_cmd = ctrl_wr && ctrl_reg[`SMB_CTRL_RUN_BIT] &&
      (ctrl_wdata == `SMB_CMD_START_IE ||
      ctrl_wdata == `SMB_CMD_START_NOIE);

   always @* begin
      state_next = state_reg;
      scl_gen_next = scl_gen_reg;
      sda_gen_next = sda_gen_reg;
      ph_cnt_next = tick ? ph_cnt_reg + 8'h01 : ph_cnt_reg;
      if (half_done) begin
         ph_cnt_next = 8'h00;
      end
      case (state_reg)
         ST_IDLE: begin
            ph_cnt_next = 8'h00;
            scl_gen_next = 1'b1;
            sda_gen_next = 1'b1;
            // The device refuses to start on a busy or held bus.
            if (start_cmd && !bus_busy_flag && scl_lvl && sda_lvl) begin
               state_next = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (half_done) begin
               sda_gen_next = 1'b0;
               state_next = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (half_done) begin
               scl_gen_next = 1'b0;
               state_next = ST_LOW;
            end
         end
         ST_LOW: begin
            // Data is released only once SCL is seen low on the bus.
            if (!scl_lvl) begin
               sda_gen_next = 1'b1;
            end
            if (half_done) begin
               scl_gen_next = 1'b1;
               state_next = ST_WAIT;
            end
         end
         ST_WAIT: begin
            ph_cnt_next = 8'h00;
            // High time starts at the observed edge, so a slow rise or
            // another party stretching SCL lengthens the period.
            if (scl_lvl) begin
               state_next = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (half_done || scl_fell) begin
               scl_gen_next = 1'b0;
               ph_cnt_next = 8'h00;
               state_next = ST_LOW;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (!ctrl_reg[`SMB_CTRL_RUN_BIT]) begin
         state_next = ST_IDLE;
         scl_gen_next = 1'b1;
         sda_gen_next = 1'b1;
      end
   end

   always @* begin
      busy_next = bus_busy_flag;
      if (sda_fell && scl_lvl) begin
         busy_next = 1'b1;
      end else if (sda_rose && scl_lvl) begin
         busy_next = 1'b0;
      end
      // A new fall wins over a clear in the same cycle.
      ovr_next = overrun_flag & ~overrun_clear;
      if (scl_fell && !bus_busy_flag && !serial_sync_mode) begin
         ovr_next = 1'b1;
      end
      scl_out_next = pin_out(scl_sel, scl_gen_reg);
      scl_oe_next = pin_oe(scl_sel, scl_gen_reg);
      sda_out_next = pin_out(sda_sel, sda_gen_reg);
      sda_oe_next = pin_oe(sda_sel, sda_gen_reg);
      sdo_out_next = pin_out(sdo_sel, sda_gen_reg);
      sdo_oe_next = serial_sync_mode & pin_oe(sdo_sel, sda_gen_reg);
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= `SMB_CTRL_RESET;
         state_reg <= ST_IDLE;
         tick_cnt_reg <= 2'h0;
         ph_cnt_reg <= 8'h00;
         scl_gen_reg <= 1'b1;
         sda_gen_reg <= 1'b1;
         bus_busy_flag <= 1'b0;
         overrun_flag <= 1'b0;
         ctrl_rdata <= `SMB_CTRL_RESET;
         interrupt_request_enable <= 1'b0;
         cmos_threshold <= 1'b0;
         scl_pin_out <= 1'b0;
         scl_pin_oe <= 1'b0;
         scl_pin_slow <= 1'b0;
         sda_pin_out <= 1'b0;
         sda_pin_oe <= 1'b0;
         sda_pin_slow <= 1'b0;
         sda_rx_enable <= 1'b0;
         sdo_pin_out <= 1'b0;
         sdo_pin_oe <= 1'b0;
         sdo_pin_slow <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            ctrl_reg <= ctrl_wdata;
         end
         state_reg <= state_next;
         tick_cnt_reg <= tick ? 2'h0 : tick_cnt_reg + 2'h1;
         ph_cnt_reg <= ph_cnt_next;
         scl_gen_reg <= scl_gen_next;
         sda_gen_reg <= sda_gen_next;
         bus_busy_flag <= busy_next;
         overrun_flag <= ovr_next;
         ctrl_rdata <= {ctrl_reg[7:3], busy_next, ctrl_reg[1:0]};
         interrupt_request_enable <= ctrl_reg[`SMB_CTRL_IE_BIT];
         cmos_threshold <= input_threshold_select;
         scl_pin_out <= scl_out_next;
         scl_pin_oe <= scl_oe_next;
         scl_pin_slow <= slow_output_select | (scl_sel == `SMB_SEL_SLOW);
         sda_pin_out <= sda_out_next;
         sda_pin_oe <= sda_oe_next;
         sda_pin_slow <= slow_output_select | (sda_sel == `SMB_SEL_SLOW);
         sda_rx_enable <= 1'b1;
         sdo_pin_out <= sdo_out_next;
         sdo_pin_oe <= sdo_oe_next;
         sdo_pin_slow <= (sdo_sel == `SMB_SEL_SLOW);
      end
   end
endmodule

// File: verilog/smb_regs.vh
/*
 * Constants of the single master bus unit: control codes, field positions,
 * reset values, pin output modes and clock divider factors.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SMB_REGS_VH
`define SMB_REGS_VH

`define SMB_CTRL_RESET 8'h00
`define SMB_CTRL_RUN_BIT 7
`define SMB_CTRL_BUSY_BIT 2
`define SMB_CTRL_IE_BIT 0
`define SMB_CMD_START_IE 8'hed
`define SMB_CMD_START_NOIE 8'hec

`define SMB_MODE_GPIO 2'h0
`define SMB_MODE_OPEN 2'h1
`define SMB_MODE_CMOS 2'h2
`define SMB_MODE_OD 2'h3

`define SMB_SEL_OPEN 4'hf
`define SMB_SEL_CMOS 4'h9
`define SMB_SEL_SLOW 4'he
`define SMB_SEL_OD 4'hd

`define SMB_HALF_FAST 8'h01
`define SMB_HALF_STD 8'h04

`endif

// File: verilog/smb_line_sync.v
/*
 * Two flip-flop synchroniser for one bus line with edge detection.
 * Assumes line_in is asynchronous to clk.
 */
module smb_line_sync (
   input wire clk,
   input wire rst,
   input wire line_in,
   output wire level,
   output wire rose,
   output wire fell
);
   reg meta_reg;
   reg sync_reg;
   reg prev_reg;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         prev_reg <= 1'b1;
      end else begin
         meta_reg <= line_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign level = sync_reg;
   assign rose = sync_reg & ~prev_reg;
   assign fell = ~sync_reg & prev_reg;
endmodule

// File: test/smb_master_port_monitor.sv
/* Port checker of the bus unit.
   Assumes bind to smb_master_port; timing checks need fast mode, n = 4. */
module smb_master_port_monitor (
   input wire sys_clk,
   input wire rst,
   input wire ctrl_wr,
   input wire [7:0] ctrl_wdata,
   input wire [7:0] ctrl_rdata,
   input wire interrupt_request_enable,
   input wire bus_busy_flag,
   input wire overrun_flag,
   input wire [1:0] filter_divider_field,
   input wire speed_mode_select,
   input wire [4:0] scl_divider_field,
   input wire serial_sync_mode,
   input wire slow_output_select,
   input wire [6:4] port_function_select_a,
   input wire [6:4] port_function_select_b,
   input wire [6:4] port_output_latch,
   input wire [6:4] port_direction_bits,
   input wire scl_pin_in,
   input wire scl_pin_oe,
   input wire scl_pin_slow,
   input wire sda_pin_in,
   input wire sda_pin_oe,
   input wire sda_pin_slow
);
   timeunit 1ns;
   timeprecision 1ps;
   wire [3:0] clk_mode = {port_function_select_a[4],
      port_function_select_b[4], port_output_latch[4], port_direction_bits[4]};
   wire cfg = clk_mode == 4'hd && filter_divider_field == 2'h0 &&
      !speed_mode_select && scl_divider_field == 5'h04;
   wire run = ctrl_rdata[7];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence start_cmd;
      ctrl_wr && ctrl_wdata[7:1] == 7'h76 && run && !bus_busy_flag &&
      scl_pin_in && sda_pin_in && cfg;
   endsequence
   sequence start_on_bus;
      $fell(sda_pin_in) && scl_pin_in;
   endsequence
   AST_SLOW: assert property (slow_output_select [*3] |->
      scl_pin_slow && sda_pin_slow) else $error("slow drive missing");
   AST_IE: assert property (ctrl_wr |-> ##2
      interrupt_request_enable == $past(ctrl_wdata[0], 2))
      else $error("enable bit wrong");
   AST_START: assert property (start_cmd |-> ##[7:9] $rose(sda_pin_oe))
      else $error("start not driven in time");
   AST_HALF: assert property ($rose(sda_pin_oe) && cfg && run |->
      ##[4:6] $rose(scl_pin_oe)) else $error("first half wrong");
   AST_LOW: assert property ($rose(scl_pin_oe) && cfg |->
      scl_pin_oe [*4]) else $error("clock low too short");
   AST_HIGH: assert property ($rose(scl_pin_in) && cfg && run |->
      !scl_pin_oe [*5]) else $error("clock high too short");
   AST_BUSY: assert property (start_on_bus |-> ##[2:4] bus_busy_flag)
      else $error("busy not set");
   AST_OVR: assert property ($fell(scl_pin_in) && !bus_busy_flag &&
      !serial_sync_mode |-> ##[2:4] overrun_flag) else $error("no overrun");
endmodule
bind smb_master_port smb_master_port_monitor mon (.*);

// File: test/smb_bus_partner.sv
/* Far side of the bus: pull-ups, another master and a stretching slave.
   Assumes the unit drives its pins open drain. */
module smb_bus_partner (
   input wire scl_pin_oe,
   input wire scl_pin_out,
   input wire sda_pin_oe,
   input wire sda_pin_out,
   output wire scl_pin_in,
   output wire sda_pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ext_scl = 1'b1;
   logic ext_sda = 1'b1;
   logic hold = 1'b0;
   int stretch = 0;
   assign scl_pin_in = (scl_pin_oe ? scl_pin_out : 1'b1) & ext_scl & !hold;
   assign sda_pin_in = (sda_pin_oe ? sda_pin_out : 1'b1) & ext_sda;
   always @(negedge scl_pin_in) begin
      if (stretch > 0) begin
         hold = 1'b1;
         #(stretch);
         hold = 1'b0;
      end
   end
   task start_c();
      ext_sda = 1'b0;
      #80;
   endtask
   task stop_c();
      ext_sda = 1'b0;
      #80;
      ext_sda = 1'b1;
      #80;
   endtask
   task pulse();
      ext_scl = 1'b0;
      #80;
      ext_scl = 1'b1;
      #80;
   endtask
endmodule

// File: test/smb_master_port_tb_top.sv
/* Self-checking bench of the bus unit: pin modes, flags, start timing.
   Assumes the partner model stands on the bus lines. */
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
   $display("Error at %0t: mismatch", $time); end end
module smb_master_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, rst = 1'b1, ctrl_wr = 1'b0, overrun_clear = 1'b0;
   logic speed_mode_select = 1'b0, serial_sync_mode = 1'b0;
   logic slow_output_select = 1'b0, input_threshold_select = 1'b1;
   logic [7:0] ctrl_wdata = 8'h00;
   logic [1:0] filter_divider_field = 2'h0;
   logic [4:0] scl_divider_field = 5'h04;
   logic [6:4] port_function_select_a = 3'h7, port_function_select_b = 3'h7;
   logic [6:4] port_output_latch = 3'h7, port_direction_bits = 3'h7;
   wire [7:0] ctrl_rdata;
   wire interrupt_request_enable, bus_busy_flag, overrun_flag, cmos_threshold;
   wire scl_pin_in, scl_pin_out, scl_pin_oe, scl_pin_slow, sda_rx_enable;
   wire sda_pin_in, sda_pin_out, sda_pin_oe, sda_pin_slow;
   wire sdo_pin_out, sdo_pin_oe, sdo_pin_slow;
   int failures = 0, n_compared = 0, n;
   logic [3:0] modes [6] = '{4'hf, 4'h9, 4'he, 4'hd, 4'h0, 4'h1};
   logic [5:0] oe_exp = 6'b010110, slow_exp = 6'b000100;
   logic [5:0] out_exp = 6'b000110;
   smb_master_port dut (.*);
   smb_bus_partner bus (.*);
   always #2 sys_clk = ~sys_clk;
   task stop_test();
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task wr(input logic [7:0] d);
      @(posedge sys_clk);
      ctrl_wr <= 1'b1;
      ctrl_wdata <= d;
      @(posedge sys_clk);
      ctrl_wr <= 1'b0;
   endtask
   task set_mode(input logic [3:0] m);
      @(posedge sys_clk);
      port_function_select_a <= {3{m[3]}};
      port_function_select_b <= {3{m[2]}};
      port_output_latch <= {3{m[1]}};
      port_direction_bits <= {3{m[0]}};
   endtask
   task count_rise(input logic pick, output int k);
      k = 0;
      do begin
         @(posedge sys_clk);
         #1;
         k++;
      end while ((pick ? scl_pin_oe : sda_pin_oe) !== 1'b1 && k < 99);
   endtask
   initial begin
      #100000;
      failures++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      serial_sync_mode <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         set_mode(modes[i]);
         tick(4);
         `CHK(scl_pin_oe, oe_exp[i])
         `CHK(sda_pin_oe, oe_exp[i])
         `CHK(sdo_pin_oe, oe_exp[i])
         `CHK(scl_pin_slow, slow_exp[i])
         `CHK(sda_rx_enable, 1'b1)
         `CHK(scl_pin_out, out_exp[i])
         `CHK(sda_pin_out, out_exp[i])
         `CHK(sdo_pin_out, out_exp[i])
         `CHK(sdo_pin_slow, slow_exp[i])
      end
      @(posedge sys_clk);
      slow_output_select <= 1'b1;
      tick(4);
      `CHK({scl_pin_slow, sda_pin_slow}, 2'b11)
      @(posedge sys_clk);
      slow_output_select <= 1'b0;
      serial_sync_mode <= 1'b0;
      set_mode(4'hd);
      wr(8'h80);
      tick(20);
      `CHK(cmos_threshold, 1'b1)
      `CHK(ctrl_rdata, 8'h80)
      `CHK({bus_busy_flag, overrun_flag}, 2'b00)
      bus.pulse();
      `CHK(overrun_flag, 1'b1)
      @(posedge sys_clk);
      overrun_clear <= 1'b1;
      @(posedge sys_clk);
      overrun_clear <= 1'b0;
      tick(3);
      `CHK(overrun_flag, 1'b0)
      bus.start_c();
      `CHK(bus_busy_flag, 1'b1)
      wr(8'hed);
      tick(40);
      `CHK(sda_pin_oe, 1'b0)
      bus.stop_c();
      `CHK(bus_busy_flag, 1'b0)
      for (int i = 0; i < 2; i++) begin
         bus.stretch = i * 100;
         wr({7'h76, i[0]});
         count_rise(1'b0, n);
         `CHK(n, 6)
         count_rise(1'b1, n);
         `CHK(n, 5)
         `CHK(bus_busy_flag, 1'b1)
         `CHK(interrupt_request_enable, i[0])
         tick(200);
         wr(8'h00);
         tick(3);
         `CHK({scl_pin_oe, sda_pin_oe}, 2'b00)
         bus.stop_c();
         `CHK(bus_busy_flag, 1'b0)
         wr(8'h80);
         tick(20);
      end
      stop_test();
   end
endmodule
